// ### hra_pkg.sv
/*
  Shared constants of the host RAM access control block: register index
  codes, field positions, reset values and the consecutive-mode enumeration.
  Assumes a single 32-bit host data bus and a 32-bit internal CPU bus.
*/
package hra_pkg;

  // register index codes as written into the index field
  localparam logic [5:0]  IDX_STATUS_CONTROL = 6'h02;
  localparam logic [5:0]  IDX_MEMORY_CONTROL = 6'h03;
  localparam logic [5:0]  IDX_DATA_WINDOW    = 6'h04;
  localparam logic [5:0]  IDX_ADDR_POINTER   = 6'h05;

  // status/control fields
  localparam int          BOOT_MODE_BIT      = 5;
  localparam int          CPU_ENDIAN_BIT     = 1;
  localparam int          HOST_ORDER_BIT     = 0;
  localparam logic [31:0] STATUS_FIXED_ONES  = 32'h0000_0040;

  // memory control fields
  localparam int          LOCK_BIT           = 7;
  localparam int          WRITE_TRIG_BIT     = 5;
  localparam int          READ_TRIG_BIT      = 3;

  // reset values
  localparam logic        CTRL_BIT_RESET     = 1'h0;
  localparam logic [31:0] WORD_RESET         = 32'h0000_0000;
  localparam logic [5:0]  INDEX_RESET        = 6'h00;

  typedef enum logic [2:0] {
    MODE_IDLE    = 3'b001,
    MODE_CONS_RD = 3'b010,
    MODE_CONS_WR = 3'b100
  } hra_mode_type;

endpackage

// ### hra_byte_swap.sv
/*
  Byte lane reverser for a 32-bit word, used for both byte-order selections.
  Purely combinational; the caller registers the result where needed.
*/
`timescale 1ns/1ps
`default_nettype none
module hra_byte_swap (
  input  wire logic        swap_i,
  input  wire logic [31:0] word_i,
  output logic      [31:0] word_o
);

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign word_o[8*b +: 8] = swap_i ? word_i[8*(3-b) +: 8] : word_i[8*b +: 8];
    end
  endgenerate

endmodule
`default_nettype wire

// ### hra_access_ctrl.sv
/*
  Host RAM access control: status/control and memory control registers, the
  data window, address pointer, index register and the shared buffer RAM.
  Assumes host strobes and bus arrive asynchronously and stay stable for
  several clocks; the CPU bus is synchronous to CLK_I.
*/
`timescale 1ns/1ps
`default_nettype none
module hra_access_ctrl #(
  parameter int RAM_AW = 10
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic              BOOT_SELECT_PIN_I,
  input  wire logic              HOST_RD_N_I,
  input  wire logic              HOST_WR_N_I,
  input  wire logic              REGISTER_SELECT_PIN_I,
  input  wire logic [31:0]       HOST_DATA_I,
  output logic      [31:0]       HOST_DATA_O,
  output logic                   HOST_DATA_OE_O,
  input  wire logic              CPU_SEL_I,
  input  wire logic              CPU_WE_I,
  input  wire logic              CPU_RAM_I,
  input  wire logic [RAM_AW-1:0] CPU_ADDR_I,
  input  wire logic [31:0]       CPU_WDATA_I,
  output logic      [31:0]       CPU_RDATA_O
);

  localparam int PTR_W = RAM_AW + 2;
  logic [2:0]              rd_s_q, wr_s_q;
  logic [1:0]              rs_s_q, boot_s_q;
  logic [31:0]             data_s1_q, data_s2_q;
  logic                    boot_mode_flag_q, boot_done_q;
  logic                    cpu_side_endian_q, host_side_byte_order_q;
  logic                    lock_q, ram_read_trigger_q, ram_write_trigger_q;
  logic                    wr_pend_q, rd_pend_q;
  hra_pkg::hra_mode_type   mode_q;
  logic [5:0]              register_index_field_q, cpu_idx;
  logic [31:0]             host_data_window_q;
  logic [PTR_W-1:0]        ram_address_pointer_q;
  logic [31:0]             shared_buffer_ram_q [2**RAM_AW];
  logic [31:0]             host_oe_word, host_wdata, host_rdata_sw, cpu_wdata_sw, cpu_ram_sw;
  logic [31:0]             status_val, memctl_val, reg_val;
  logic                    h_wr_ev, h_rd_ev, h_rd_end, host_reg_wr, host_mcr_wr;
  logic                    cpu_reg_wr, cpu_ram_wr;
  logic [RAM_AW-1:0]       ptr_idx;

  // synchronisers: first stage feeds only the second
  // strobes reset to their idle high level, else a false edge could follow reset
  always_ff @(posedge CLK_I) begin
    rd_s_q    <= RST_N_I ? {rd_s_q[1:0], HOST_RD_N_I} : 3'h7;
    wr_s_q    <= RST_N_I ? {wr_s_q[1:0], HOST_WR_N_I} : 3'h7;
    rs_s_q    <= {rs_s_q[0], REGISTER_SELECT_PIN_I};
    boot_s_q  <= {boot_s_q[0], BOOT_SELECT_PIN_I};
    data_s1_q <= HOST_DATA_I;
    data_s2_q <= data_s1_q;
  end

  // write data is taken on the strobe's rising edge, when it is stable
  assign h_wr_ev  = ~wr_s_q[2] & wr_s_q[1];
  assign h_rd_ev  = rd_s_q[2] & ~rd_s_q[1];
  assign h_rd_end = ~rd_s_q[2] & rd_s_q[1];
  assign host_reg_wr = h_wr_ev & ~rs_s_q[1];
  assign host_mcr_wr = host_reg_wr & (register_index_field_q == hra_pkg::IDX_MEMORY_CONTROL);
  assign cpu_reg_wr  = CPU_SEL_I & CPU_WE_I & ~CPU_RAM_I;
  // host owns the RAM port on a collision; the CPU write is dropped
  assign cpu_ram_wr  = CPU_SEL_I & CPU_WE_I & CPU_RAM_I & ~wr_pend_q;
  assign ptr_idx     = ram_address_pointer_q[PTR_W-1:2];
  assign cpu_idx     = 6'(CPU_ADDR_I);

  hra_byte_swap u_host_in  (.swap_i(host_side_byte_order_q), .word_i(data_s2_q), .word_o(host_wdata));
  hra_byte_swap u_host_out (.swap_i(host_side_byte_order_q), .word_i(host_oe_word), .word_o(host_rdata_sw));
  hra_byte_swap u_cpu_in   (.swap_i(cpu_side_endian_q), .word_i(CPU_WDATA_I), .word_o(cpu_wdata_sw));
  hra_byte_swap u_cpu_out  (.swap_i(cpu_side_endian_q), .word_i(shared_buffer_ram_q[CPU_ADDR_I]), .word_o(cpu_ram_sw));

  always_comb begin
    status_val = hra_pkg::STATUS_FIXED_ONES;
    status_val[hra_pkg::BOOT_MODE_BIT]  = boot_mode_flag_q;
    status_val[hra_pkg::CPU_ENDIAN_BIT] = cpu_side_endian_q;
    status_val[hra_pkg::HOST_ORDER_BIT] = host_side_byte_order_q;
  end

  always_comb begin
    memctl_val = hra_pkg::WORD_RESET;
    memctl_val[hra_pkg::LOCK_BIT]       = lock_q;
    memctl_val[hra_pkg::WRITE_TRIG_BIT] = ram_write_trigger_q;
    memctl_val[hra_pkg::READ_TRIG_BIT]  = ram_read_trigger_q;
  end

  always_comb begin
    case (register_index_field_q)
      hra_pkg::IDX_STATUS_CONTROL: reg_val = status_val;
      hra_pkg::IDX_MEMORY_CONTROL: reg_val = memctl_val;
      hra_pkg::IDX_DATA_WINDOW:    reg_val = host_data_window_q;
      hra_pkg::IDX_ADDR_POINTER:   reg_val = {{(32-PTR_W){1'b0}}, ram_address_pointer_q};
      default:                     reg_val = hra_pkg::WORD_RESET;
    endcase
    host_oe_word = rs_s_q[1] ? {26'h0000000, register_index_field_q} : reg_val;
  end

  // boot pin caught after reset release
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      boot_mode_flag_q <= hra_pkg::CTRL_BIT_RESET;
      boot_done_q      <= 1'b0;
    end else if (!boot_done_q) begin
      boot_mode_flag_q <= boot_s_q[1];
      boot_done_q      <= 1'b1;
    end
  end

  // status/control: host write wins over a same-cycle CPU write
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cpu_side_endian_q      <= hra_pkg::CTRL_BIT_RESET;
      host_side_byte_order_q <= hra_pkg::CTRL_BIT_RESET;
    end else if (host_reg_wr && register_index_field_q == hra_pkg::IDX_STATUS_CONTROL) begin
      cpu_side_endian_q      <= host_wdata[hra_pkg::CPU_ENDIAN_BIT];
      host_side_byte_order_q <= host_wdata[hra_pkg::HOST_ORDER_BIT];
    end else if (cpu_reg_wr && cpu_idx == hra_pkg::IDX_STATUS_CONTROL) begin
      cpu_side_endian_q      <= CPU_WDATA_I[hra_pkg::CPU_ENDIAN_BIT];
      host_side_byte_order_q <= CPU_WDATA_I[hra_pkg::HOST_ORDER_BIT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      register_index_field_q <= hra_pkg::INDEX_RESET;
      ram_address_pointer_q  <= '0;
    end else if (h_wr_ev && rs_s_q[1]) begin
      register_index_field_q <= host_wdata[5:0];
    end else if (host_reg_wr && register_index_field_q == hra_pkg::IDX_ADDR_POINTER) begin
      ram_address_pointer_q  <= host_wdata[PTR_W-1:0];
    end
  end

  // memory control written only by the host, select low
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      lock_q              <= hra_pkg::CTRL_BIT_RESET;
      ram_write_trigger_q <= hra_pkg::CTRL_BIT_RESET;
      ram_read_trigger_q  <= hra_pkg::CTRL_BIT_RESET;
    end else if (host_mcr_wr) begin
      lock_q              <= host_wdata[hra_pkg::LOCK_BIT];
      ram_write_trigger_q <= host_wdata[hra_pkg::WRITE_TRIG_BIT];
      ram_read_trigger_q  <= host_wdata[hra_pkg::READ_TRIG_BIT] & ~host_wdata[hra_pkg::WRITE_TRIG_BIT];
    end else begin
      if (wr_pend_q && !lock_q) begin
        ram_write_trigger_q <= 1'b0;
      end
      if (rd_pend_q && !lock_q) begin
        ram_read_trigger_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mode_q <= hra_pkg::MODE_IDLE;
    end else if (host_mcr_wr) begin
      case ({host_wdata[hra_pkg::LOCK_BIT], host_wdata[hra_pkg::WRITE_TRIG_BIT], host_wdata[hra_pkg::READ_TRIG_BIT]})
        3'b110, 3'b111: mode_q <= hra_pkg::MODE_CONS_WR;
        3'b101: mode_q <= hra_pkg::MODE_CONS_RD;
        default: mode_q <= hra_pkg::MODE_IDLE;
      endcase
    end
  end

  // pending RAM operations, done the cycle after the triggering event
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else begin
      // write trigger or streamed window write
      wr_pend_q <= (host_mcr_wr & host_wdata[hra_pkg::WRITE_TRIG_BIT]) |
                   (host_reg_wr & register_index_field_q == hra_pkg::IDX_DATA_WINDOW &
                    mode_q == hra_pkg::MODE_CONS_WR);
      // read trigger or refetch after streamed read
      rd_pend_q <= (host_mcr_wr & host_wdata[hra_pkg::READ_TRIG_BIT] & ~host_wdata[hra_pkg::WRITE_TRIG_BIT]) |
                   (h_rd_end & ~rs_s_q[1] & register_index_field_q == hra_pkg::IDX_DATA_WINDOW &
                    mode_q == hra_pkg::MODE_CONS_RD);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      host_data_window_q <= hra_pkg::WORD_RESET;
    end else if (host_reg_wr && register_index_field_q == hra_pkg::IDX_DATA_WINDOW) begin
      host_data_window_q <= host_wdata;
    end else if (rd_pend_q) begin
      host_data_window_q <= shared_buffer_ram_q[ptr_idx];
    end
  end

  // RAM has no reset; contents are undefined until written
  always_ff @(posedge CLK_I) begin
    if (wr_pend_q) begin
      shared_buffer_ram_q[ptr_idx] <= host_data_window_q;
    end else if (cpu_ram_wr) begin
      shared_buffer_ram_q[CPU_ADDR_I] <= cpu_wdata_sw;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      CPU_RDATA_O    <= hra_pkg::WORD_RESET;
      HOST_DATA_O    <= hra_pkg::WORD_RESET;
      HOST_DATA_OE_O <= 1'b0;
    end else begin
      if (CPU_SEL_I && !CPU_WE_I) begin
        CPU_RDATA_O <= CPU_RAM_I ? cpu_ram_sw : (cpu_idx == hra_pkg::IDX_STATUS_CONTROL) ? status_val :
                       (cpu_idx == hra_pkg::IDX_MEMORY_CONTROL) ? memctl_val : hra_pkg::WORD_RESET;
      end
      if (h_rd_ev) begin
        HOST_DATA_O <= host_rdata_sw;
      end
      HOST_DATA_OE_O <= ~rd_s_q[1];
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_boot_flag;
    boot_done_q |=> $stable(boot_mode_flag_q);
  endproperty
  a_boot_flag: assert property (p_boot_flag) else $error("boot flag changed after capture");
  property p_status_rsvd;
    status_val[4:2] == 3'h0;
  endproperty
  a_status_rsvd: assert property (p_status_rsvd) else $error("status bits 4..2 not zero");
  property p_cpu_endian;
    cpu_reg_wr && cpu_idx == hra_pkg::IDX_STATUS_CONTROL && !host_reg_wr
      |=> cpu_side_endian_q == $past(CPU_WDATA_I[1]);
  endproperty
  a_cpu_endian: assert property (p_cpu_endian) else $error("cpu endian not written");
  property p_host_order;
    host_reg_wr && register_index_field_q == hra_pkg::IDX_STATUS_CONTROL
      |=> host_side_byte_order_q == $past(host_wdata[0]);
  endproperty
  a_host_order: assert property (p_host_order) else $error("host byte order not written");
  property p_cpu_no_mcr;
    cpu_reg_wr && !host_mcr_wr && !wr_pend_q && !rd_pend_q |=> $stable(memctl_val);
  endproperty
  a_cpu_no_mcr: assert property (p_cpu_no_mcr) else $error("cpu changed memory control");
  property p_mcr_rsvd;
    memctl_val[31:8] == 24'h000000 && !memctl_val[6];
  endproperty
  a_mcr_rsvd: assert property (p_mcr_rsvd) else $error("memory control reserved bit set");
  property p_lock_hold;
    lock_q && !host_mcr_wr |=> $stable(ram_write_trigger_q) && $stable(ram_read_trigger_q);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("trigger changed under lock");
  property p_ram_write;
    host_mcr_wr && host_wdata[5] |=> wr_pend_q ##1 shared_buffer_ram_q[$past(ptr_idx)] == $past(host_data_window_q);
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("window not stored to RAM");
  property p_single_wr;
    host_mcr_wr && host_wdata[5] && !host_wdata[7] |=> ##1 !ram_write_trigger_q;
  endproperty
  a_single_wr: assert property (p_single_wr) else $error("write trigger did not self-clear");
  property p_read_fetch;
    rd_pend_q && !host_reg_wr |=> host_data_window_q == $past(shared_buffer_ram_q[ptr_idx]);
  endproperty
  a_read_fetch: assert property (p_read_fetch) else $error("RAM word not fetched");
  property p_cons_end;
    host_mcr_wr && !(host_wdata[7] && host_wdata[5]) |=> mode_q != hra_pkg::MODE_CONS_WR;
  endproperty
  a_cons_end: assert property (p_cons_end) else $error("consecutive write not ended");

endmodule
`default_nettype wire

// ### hra_host_model.sv
/*
  External host model: reaches the block's registers through the index
  register and the select pin, one strobe at a time.
  Assumes it shares the device clock and drives just after its rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module hra_host_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] data_i,
  input  wire logic        oe_i,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic             rs_o,
  output logic      [31:0] data_o
);
  initial begin
    rd_n_o = 1'h1;
    wr_n_o = 1'h1;
    rs_o   = 1'h1;
    data_o = 32'h0;
  end

  task automatic acc_wr(input logic rs, input logic [31:0] d);
    @(posedge clk_i);
    rs_o   <= rs;
    data_o <= d;
    wr_n_o <= 1'h0;
    repeat (3) @(posedge clk_i);
    wr_n_o <= 1'h1;
    // data is caught through a synchroniser, so it stays a while after the strobe
    repeat (6) @(posedge clk_i);
    data_o <= ~d;
  endtask

  task automatic acc_rd(input logic rs, output logic [31:0] d);
    @(posedge clk_i);
    rs_o   <= rs;
    rd_n_o <= 1'h0;
    repeat (6) @(posedge clk_i);
    // an undriven bus hands back the inverse, so the caller's compare trips
    d = oe_i ? data_i : ~data_i;
    rd_n_o <= 1'h1;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic reg_wr(input logic [5:0] idx, input logic [31:0] d);
    acc_wr(1'h1, {26'h0, idx});
    acc_wr(1'h0, d);
  endtask

  task automatic reg_rd(input logic [5:0] idx, output logic [31:0] d);
    acc_wr(1'h1, {26'h0, idx});
    acc_rd(1'h0, d);
  endtask
endmodule
`default_nettype wire

// ### host_ram_access_control_tb_top.sv
/*
  Testbench of the host RAM access control block: host model plus CPU bus.
  Assumes a RAM of 16 words and the register indices of the package.
*/
`timescale 1ns/1ps
`default_nettype none
module host_ram_access_control_tb_top;
  logic        clk;
  logic        rst_n;
  logic        boot;
  logic        cpu_sel;
  logic        cpu_we;
  logic        cpu_ram;
  logic [3:0]  cpu_addr;
  logic [31:0] cpu_wdata;
  logic [31:0] cpu_rdata;
  logic        rd_n;
  logic        wr_n;
  logic        rs;
  logic [31:0] h_din;
  logic [31:0] h_dout;
  logic        h_oe;
  logic [31:0] rnd;
  logic [31:0] d;
  logic [31:0] v;
  logic [3:0]  q;
  int          fail_count;
  int          num_checks;

  hra_access_ctrl #(.RAM_AW(4)) dut (
    .CLK_I(clk), .RST_N_I(rst_n), .BOOT_SELECT_PIN_I(boot), .HOST_RD_N_I(rd_n),
    .HOST_WR_N_I(wr_n), .REGISTER_SELECT_PIN_I(rs), .HOST_DATA_I(h_din), .HOST_DATA_O(h_dout),
    .HOST_DATA_OE_O(h_oe), .CPU_SEL_I(cpu_sel), .CPU_WE_I(cpu_we), .CPU_RAM_I(cpu_ram),
    .CPU_ADDR_I(cpu_addr), .CPU_WDATA_I(cpu_wdata), .CPU_RDATA_O(cpu_rdata)
  );

  hra_host_model host (
    .clk_i(clk), .data_i(h_dout), .oe_i(h_oe), .rd_n_o(rd_n), .wr_n_o(wr_n), .rs_o(rs), .data_o(h_din)
  );

  always #10 clk = ~clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] swap32(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
  function automatic logic [31:0] stat_exp(input logic b, input logic [31:0] w);
    return hra_pkg::STATUS_FIXED_ONES | {26'h0, b, 3'h0, w[1:0]};
  endfunction

  task automatic rn();
    rnd = lfsr_next(rnd);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic b);
    @(posedge clk);
    rst_n <= 1'h0;
    boot  <= b;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
  endtask
  // one strobe cycle; read data is sampled half a cycle after it is registered
  task automatic cpu_acc(input logic we, input logic ram, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk);
    cpu_sel   <= 1'h1;
    cpu_we    <= we;
    cpu_ram   <= ram;
    cpu_addr  <= a;
    cpu_wdata <= wd;
    @(posedge clk);
    cpu_sel   <= 1'h0;
    cpu_wdata <= ~wd;
    @(negedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("CHECK FAILED t=%0t run did not complete", $time);
    close_out();
  end

  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    boot = 1'h1;
    cpu_sel = 1'h0;
    cpu_we = 1'h0;
    cpu_ram = 1'h0;
    cpu_addr = 4'h0;
    cpu_wdata = 32'h0;
    rnd = 32'h3294;
    fail_count = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    check({31'h0, h_oe}, 32'h0, "oe idle after reset");
    cpu_acc(1'h0, 1'h0, 4'h2, 32'h0);
    check(cpu_rdata, stat_exp(1'h1, 32'h0), "status reset");
    cpu_acc(1'h0, 1'h0, 4'h3, 32'h0);
    check(cpu_rdata, 32'h0, "mcr reset");
    rn();
    cpu_acc(1'h1, 1'h0, 4'h2, rnd);
    cpu_acc(1'h0, 1'h0, 4'h2, 32'h0);
    check(cpu_rdata, stat_exp(1'h1, rnd), "status rw");
    cpu_acc(1'h1, 1'h0, 4'h2, 32'h0);
    cpu_acc(1'h1, 1'h0, 4'h3, 32'hFFFF_FFFF);
    cpu_acc(1'h0, 1'h0, 4'h3, 32'h0);
    check(cpu_rdata, 32'h0, "cpu mcr write");
    done("registers");
    // never both triggers in one access
    for (int i = 0; i < 3; i++) begin
      rn();
      q = rnd[3:0];
      rn();
      d = rnd;
      host.reg_wr(6'h05, {26'h0, q, 2'h0});
      host.reg_wr(6'h04, d);
      host.reg_wr(6'h03, 32'h20);
      host.reg_rd(6'h03, v);
      check(v, 32'h0, "write trigger clear");
      cpu_acc(1'h0, 1'h1, q, 32'h0);
      check(cpu_rdata, d, "single write");
      q = q ^ 4'h1;
      rn();
      cpu_acc(1'h1, 1'h1, q, rnd);
      host.reg_wr(6'h05, {26'h0, q, 2'h0});
      host.reg_wr(6'h03, 32'h08);
      host.reg_rd(6'h03, v);
      check(v, 32'h0, "read trigger clear");
      host.reg_rd(6'h04, v);
      check(v, rnd, "single read");
    end
    done("single");
    rn();
    host.reg_wr(6'h03, {rnd[31:8], 8'hC0});
    cpu_acc(1'h0, 1'h0, 4'h3, 32'h0);
    check(cpu_rdata, 32'h80, "mcr reserved");
    host.reg_wr(6'h03, 32'hA0);
    host.reg_rd(6'h03, v);
    check(v, 32'hA0, "write lock held");
    rn();
    host.reg_wr(6'h04, rnd);
    cpu_acc(1'h0, 1'h1, q, 32'h0);
    check(cpu_rdata, rnd, "stream write 1");
    rn();
    d = rnd;
    host.acc_wr(1'h0, d);
    cpu_acc(1'h0, 1'h1, q, 32'h0);
    check(cpu_rdata, d, "stream write 2");
    host.reg_wr(6'h03, 32'h0);
    rn();
    host.reg_wr(6'h04, rnd);
    cpu_acc(1'h0, 1'h1, q, 32'h0);
    check(cpu_rdata, d, "stream write end");
    cpu_acc(1'h1, 1'h0, 4'h2, 32'h2);
    cpu_acc(1'h0, 1'h1, q, 32'h0);
    check(cpu_rdata, swap32(d), "cpu endian");
    cpu_acc(1'h1, 1'h0, 4'h2, 32'h0);
    done("stream write");
    rn();
    d = rnd;
    cpu_acc(1'h1, 1'h1, q, d);
    host.reg_wr(6'h03, 32'h88);
    rn();
    cpu_acc(1'h1, 1'h1, q, rnd);
    cpu_acc(1'h1, 1'h0, 4'h3, 32'h0);
    host.reg_rd(6'h03, v);
    check(v, 32'h88, "cpu cannot unlock");
    host.reg_rd(6'h04, v);
    check(v, d, "stream read 1");
    host.acc_rd(1'h0, v);
    check(v, rnd, "stream read 2");
    check({31'h0, h_oe}, 32'h0, "oe released after read");
    host.reg_wr(6'h03, 32'h0);
    done("stream read");
    host.acc_wr(1'h1, 32'h2);
    cpu_acc(1'h1, 1'h0, 4'h2, 32'h1);
    host.acc_rd(1'h0, v);
    check(v, swap32(stat_exp(1'h1, 32'h1)), "host byte order");
    cpu_acc(1'h1, 1'h0, 4'h2, 32'h0);
    do_reset(1'h0);
    cpu_acc(1'h0, 1'h0, 4'h2, 32'h0);
    check(cpu_rdata, stat_exp(1'h0, 32'h0), "boot low");
    done("byte order and boot");
    close_out();
  end
endmodule
`default_nettype wire
